// ===== design/wss_top.sv
// waveform source select and output steering, with APB register access
// assumes: APB master on i_ref_clk; sources arrive from other domains
//
// Operation
// - route source chosen by 4-bit select code
// - select register upper nibble reads zero
// - output d steered data or override
// - output c steered data or override
// - output b override when steering off in mode 000 or 001
// - output a steered data or override
// - polarity bit set inverts the steered data, not the override level
// - mode 001 double-buffers steering enables
//
// Added by the designer: the register offsets and the APB slave port.
`include "wss_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module wss_top
(
   input  wire logic                      i_ref_clk,
   input  wire logic                      i_rst_b,
   input  wire logic                      i_psel,
   input  wire logic                      i_penable,
   input  wire logic                      i_pwrite,
   input  wire logic [`WSS_ADDR_W-1:0]    i_paddr,
   input  wire logic [31:0]               i_pwdata,
   output var  logic [31:0]               o_prdata,
   output var  logic                      o_pready,
   output var  logic                      o_pslverr,
   input  wire wss_pkg::wss_src_t         i_sources,
   output var  logic [`WSS_NUM_LANES-1:0] o_wave_out
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic addr_mapped(input logic [`WSS_ADDR_W-1:0] a);
      addr_mapped = (a == `WSS_OFS_CONTROL) || (a == `WSS_OFS_SRC_SELECT) ||
                    (a == `WSS_OFS_STEERING);
   endfunction

   function automatic logic pick_source(input logic [`WSS_NUM_SRC-1:0] s,
                                        input logic [3:0]              code);
      // reserved codes give a quiet low
      if (code > `WSS_SRC_LAST)
         pick_source = 1'b0;
      else
         pick_source = s[code];
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [3:0]                src_select_q;
   logic [2:0]                mode_q;
   wss_pkg::wss_lane_cfg_t    cfg_q;
   logic [3:0]                steer_active_q;
   logic [`WSS_NUM_SRC-1:0]   src_meta_q;
   logic [`WSS_NUM_SRC-1:0]   src_sync_q;
   logic                      data_q;
   logic                      data_prev_q;
   logic                      setup;
   logic                      wr_access;
   logic                      steer_mode;
   logic                      data_rise;
   logic [31:0]               rdata_d;

   assign setup      = i_psel && !i_penable;
   assign wr_access  = i_psel && i_penable && i_pwrite && o_pready;
   assign steer_mode = (mode_q == `WSS_MODE_STEER_ASYNC) || (mode_q == `WSS_MODE_STEER_SYNC);
   assign data_rise  = data_q && !data_prev_q;

   // ----------------------------------------------------------------
   // source synchroniser and selector
   // ----------------------------------------------------------------
   // two flops per source: every source comes from another clock domain
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         src_meta_q <= '0;
         src_sync_q <= '0;
      end
      else
      begin
         src_meta_q <= i_sources;
         src_sync_q <= src_meta_q;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         data_q      <= 1'b0;
         data_prev_q <= 1'b0;
      end
      else
      begin
         data_q      <= pick_source(src_sync_q, src_select_q);
         data_prev_q <= data_q;
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         src_select_q <= `WSS_RST_SEL;
         mode_q       <= `WSS_RST_MODE;
         cfg_q        <= '0;
      end
      else if (wr_access)
      begin
         case (i_paddr)
            `WSS_OFS_CONTROL:
            begin
               cfg_q.invert_out <= i_pwdata[`WSS_CTL_INV_LSB +: 4];
               mode_q           <= i_pwdata[`WSS_CTL_MODE_LSB +: 3];
            end
            `WSS_OFS_SRC_SELECT:
            begin
               src_select_q <= i_pwdata[3:0];
            end
            `WSS_OFS_STEERING:
            begin
               cfg_q.steer_enable   <= i_pwdata[`WSS_STR_EN_LSB +: 4];
               cfg_q.override_level <= i_pwdata[`WSS_STR_OVR_LSB +: 4];
            end
            default:
            begin
               src_select_q <= src_select_q;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // steering enables in effect
   // ----------------------------------------------------------------
   // in mode 001 new enables wait for a rising data edge so no pulse is cut short
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
         steer_active_q <= `WSS_RST_LANES;
      else if (mode_q != `WSS_MODE_STEER_SYNC)
         steer_active_q <= cfg_q.steer_enable;
      else if (data_rise)
         steer_active_q <= cfg_q.steer_enable;
   end

   // ----------------------------------------------------------------
   // APB answer: no wait states, data latched at setup
   // ----------------------------------------------------------------
   always_comb
   begin
      rdata_d = `WSS_RST_WORD;
      case (i_paddr)
         `WSS_OFS_CONTROL:
         begin
            rdata_d[`WSS_CTL_INV_LSB +: 4]  = cfg_q.invert_out;
            rdata_d[`WSS_CTL_MODE_LSB +: 3] = mode_q;
            rdata_d[`WSS_CTL_DATA_BIT]      = data_q;
         end
         `WSS_OFS_SRC_SELECT:
         begin
            rdata_d[3:0] = src_select_q;
         end
         `WSS_OFS_STEERING:
         begin
            rdata_d[`WSS_STR_EN_LSB +: 4]  = cfg_q.steer_enable;
            rdata_d[`WSS_STR_OVR_LSB +: 4] = cfg_q.override_level;
         end
         default:
         begin
            rdata_d = `WSS_RST_WORD;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
      begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= `WSS_RST_WORD;
      end
      else
      begin
         o_pready  <= setup;
         o_pslverr <= setup && !addr_mapped(i_paddr);
         if (setup && !i_pwrite)
            o_prdata <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // output lanes
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `WSS_NUM_LANES; g = g + 1)
      begin : g_lane
         wss_steer_lane u_lane
         (
            .i_ref_clk    (i_ref_clk),
            .i_rst_b      (i_rst_b),
            .i_data       (data_q),
            .i_invert     (cfg_q.invert_out[g]),
            .i_steer_en   (steer_active_q[g]),
            .i_override   (cfg_q.override_level[g]),
            .i_steer_mode (steer_mode),
            .o_out        (o_wave_out[g])
         );
      end
   endgenerate

endmodule // wss_top

`default_nettype wire

// ===== design/wss_consts.svh
// constants of the waveform source select and steering block
// assumes: included by bare name from the design files
`ifndef WSS_CONSTS_SVH
`define WSS_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define WSS_ADDR_W          8
`define WSS_OFS_CONTROL     8'h00
`define WSS_OFS_SRC_SELECT  8'h04
`define WSS_OFS_STEERING    8'h08

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define WSS_CTL_INV_LSB     0
`define WSS_CTL_MODE_LSB    4
`define WSS_CTL_DATA_BIT    8
`define WSS_STR_EN_LSB      0
`define WSS_STR_OVR_LSB     4
`define WSS_RST_SEL         4'h0
`define WSS_RST_LANES       4'h0
`define WSS_RST_MODE        3'h0
`define WSS_RST_WORD        32'h0000_0000

// ----------------------------------------------------------------
// mode codes and source codes
// ----------------------------------------------------------------
`define WSS_MODE_STEER_ASYNC 3'h0
`define WSS_MODE_STEER_SYNC  3'h1
`define WSS_SRC_LAST         4'hd
`define WSS_NUM_SRC          14
`define WSS_NUM_LANES        4

`endif

// ===== design/wss_pkg.sv
// types of the waveform source select and steering block
// assumes: compiled before every design module
package wss_pkg;

   // ----------------------------------------------------------------
   // source bundle, bit index equals select code
   // ----------------------------------------------------------------
   typedef struct packed {
      logic logic_cell_four;
      logic logic_cell_three;
      logic logic_cell_two;
      logic logic_cell_one;
      logic numeric_oscillator_one;
      logic pulse_mod_six;
      logic pulse_mod_five;
      logic capcomp_unit_four;
      logic capcomp_unit_three;
      logic capcomp_unit_two;
      logic capcomp_unit_one;
      logic comparator_two_output;
      logic comparator_one_output;
      logic remapped_pin_input;
   } wss_src_t;

   // per-lane settings, bit 0 = output a
   typedef struct packed {
      logic [3:0] invert_out;
      logic [3:0] steer_enable;
      logic [3:0] override_level;
   } wss_lane_cfg_t;

endpackage

// ===== design/wss_steer_lane.sv
// one output lane: polarity, steering and override
// assumes: data input already synchronised to i_ref_clk
`timescale 1ns/1ps
`default_nettype none

module wss_steer_lane
(
   input  wire logic i_ref_clk,
   input  wire logic i_rst_b,
   input  wire logic i_data,
   input  wire logic i_invert,
   input  wire logic i_steer_en,
   input  wire logic i_override,
   input  wire logic i_steer_mode,
   output var  logic o_out
);

   logic out_d;

   always_comb
   begin
      if (i_steer_mode)
      begin
         out_d = i_steer_en ? (i_data ^ i_invert) : i_override;
      end
      else
      begin
         // steering settings ignored outside steering modes
         out_d = i_data ^ i_invert;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_b)
         o_out <= 1'b0;
      else
         o_out <= out_d;
   end

endmodule // wss_steer_lane

`default_nettype wire

// ===== sim/wss_top_sva.sv
// checker for the waveform steering block, ports only
// assumes: bound to wss_top, one clock, synchronous active-low reset
`include "wss_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module wss_top_sva
(
   input wire logic                      i_ref_clk,
   input wire logic                      i_rst_b,
   input wire logic                      i_psel,
   input wire logic                      i_penable,
   input wire logic                      i_pwrite,
   input wire logic [`WSS_ADDR_W-1:0]    i_paddr,
   input wire logic [31:0]               i_pwdata,
   input wire logic [31:0]               o_prdata,
   input wire logic                      o_pready,
   input wire logic                      o_pslverr,
   input wire wss_pkg::wss_src_t         i_sources,
   input wire logic [`WSS_NUM_LANES-1:0] o_wave_out
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   logic mapped;
   assign mapped = (i_paddr == `WSS_OFS_CONTROL) || (i_paddr == `WSS_OFS_SRC_SELECT) || (i_paddr == `WSS_OFS_STEERING);
   sequence setup_s;
      i_psel && !i_penable;
   endsequence
   sequence answer_s;
      i_psel && i_penable && o_pready;
   endsequence
   a_rdy_after_setup: assert property (setup_s |=> answer_s) else $error("no answer after setup");
   a_rdy_one_cycle: assert property (o_pready |=> !o_pready) else $error("ready held too long");
   a_err_needs_rdy: assert property (o_pslverr |-> o_pready) else $error("error without ready");
   a_unmapped_err: assert property (o_pready && !mapped |-> o_pslverr) else $error("unmapped not refused");
   a_mapped_ok: assert property (o_pready && mapped |-> !o_pslverr) else $error("mapped refused");
   a_sel_upper_zero: assert property (o_pready && !i_pwrite && i_paddr == `WSS_OFS_SRC_SELECT |->
      o_prdata[31:4] == 28'h0) else $error("select upper bits not zero");
   a_err_read_zero: assert property (o_pready && o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
      else $error("refused read not zero");
   a_out_clear_rst: assert property ($rose(i_rst_b) |-> o_wave_out == 4'h0) else $error("outputs not cleared");
endmodule // wss_top_sva

bind wss_top wss_top_sva wss_top_sva_i (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sources(i_sources), .o_wave_out(o_wave_out));
`default_nettype wire

// ===== sim/wss_top_test.sv
// self-checking bench of the waveform steering block
// assumes: wss_top and its checker compiled before it
`include "wss_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module wss_top_test;
   logic        clk    = 1'b0;
   logic        rst_b  = 1'b0;
   logic        psel   = 1'b0;
   logic        pen    = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr  = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [13:0] srcv   = 14'h0;
   logic [31:0] prdata, rd, w;
   logic        pready, pslverr, er;
   logic [3:0]  wave, inv, en, ovr;
   logic [2:0]  mode;
   int          errors  = 0;
   int          checked = 0;
   int          cyc     = 0;

   always #20 clk = ~clk;

   wss_top wss_top_i (.i_ref_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_sources(wss_pkg::wss_src_t'(srcv)), .o_wave_out(wave));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors++;
         end_sim();
      end
   end

   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      // one idle edge so a following call never re-drives psel in the same step
      @(posedge clk);
   endtask

   task automatic settle;
      repeat (8) @(posedge clk);
   endtask

   function automatic logic [3:0] expo(logic d, logic [3:0] iv, logic [3:0] e, logic [3:0] o, logic st);
      for (int k = 0; k < 4; k++)
         expo[k] = (st && !e[k]) ? o[k] : d ^ iv[k];
   endfunction

   initial
   begin
      void'($urandom(768));
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("out reset", {28'h0, wave}, 32'h0);
      apb(1'b0, `WSS_OFS_SRC_SELECT, 32'h0);
      chk("select reset", rd, 32'h0);
      apb(1'b0, `WSS_OFS_STEERING, 32'h0);
      chk("steering reset", rd, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      chk("unmapped error", {31'h0, er}, 32'h1);
      apb(1'b1, 8'h0c, 32'hffff_ffff);
      chk("unmapped write error", {31'h0, er}, 32'h1);
      apb(1'b0, `WSS_OFS_STEERING, 32'h0);
      chk("unmapped write ignored", rd, 32'h0);
      $display("test reset done");
      for (int c = 0; c < 16; c++)
      begin
         srcv <= 14'($urandom());
         w = $urandom();
         apb(1'b1, `WSS_OFS_SRC_SELECT, {w[31:4], 4'(c)});
         settle();
         apb(1'b0, `WSS_OFS_SRC_SELECT, 32'h0);
         chk("select readback", rd, 32'(c));
         apb(1'b0, `WSS_OFS_CONTROL, 32'h0);
         chk("data in", {31'h0, rd[8]}, {31'h0, (c < 14) ? srcv[c] : 1'b0});
      end
      $display("test select done");
      apb(1'b1, `WSS_OFS_SRC_SELECT, 32'h0);
      for (int i = 0; i < 24; i++)
      begin
         mode = (i < 12) ? 3'h0 : 3'(2 + i % 6);
         {inv, en, ovr} = 12'($urandom());
         srcv <= 14'($urandom());
         apb(1'b1, `WSS_OFS_CONTROL, {25'h0, mode, inv});
         apb(1'b1, `WSS_OFS_STEERING, {24'h0, ovr, en});
         settle();
         chk("lanes", {28'h0, wave}, {28'h0, expo(srcv[0], inv, en, ovr, mode == 3'h0)});
      end
      $display("test lanes done");
      srcv <= 14'h0;
      apb(1'b1, `WSS_OFS_CONTROL, {25'h0, 3'h0, 4'hf});
      apb(1'b1, `WSS_OFS_STEERING, 32'h0);
      apb(1'b1, `WSS_OFS_CONTROL, {25'h0, 3'h1, 4'hf});
      settle();
      chk("buffer idle", {28'h0, wave}, 32'h0);
      apb(1'b1, `WSS_OFS_STEERING, 32'h0000_000f);
      settle();
      chk("buffer held", {28'h0, wave}, 32'h0);
      srcv <= 14'h1;
      settle();
      srcv <= 14'h0;
      settle();
      chk("buffer loaded", {28'h0, wave}, 32'hf);
      $display("test buffer done");
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("out mid reset", {28'h0, wave}, 32'h0);
      apb(1'b0, `WSS_OFS_STEERING, 32'h0);
      chk("steering mid reset", rd, 32'h0);
      apb(1'b0, `WSS_OFS_CONTROL, 32'h0);
      chk("control mid reset", rd, 32'h0);
      $display("test mid reset done");
      end_sim();
   end
endmodule // wss_top_test
`default_nettype wire
